/* File: inc/lfg_pkg.sv */
// constants for the legacy fast gate and port control block
package lfg_pkg;
  // ---------------------------------------------------------------
  // host side decode
  // ---------------------------------------------------------------
  localparam logic [15:0] LFG_LPC_PORT_ADDR   = 16'h0092;
  localparam logic [7:0]  LFG_CFG_ENABLE_IDX  = 8'h30;

  // ---------------------------------------------------------------
  // controller offsets from the block base
  // ---------------------------------------------------------------
  localparam int          LFG_EC_AW           = 12;
  localparam logic [11:0] LFG_OFF_PORT_BYTE   = 12'h000;
  localparam logic [11:0] LFG_OFF_GATE_CTL    = 12'h100;
  localparam logic [11:0] LFG_OFF_GATE_SET    = 12'h108;
  localparam logic [11:0] LFG_OFF_GATE_RST    = 12'h10c;
  localparam logic [11:0] LFG_OFF_PORT_EN     = 12'h330;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          LFG_BIT_ALT_RESET   = 0;
  localparam int          LFG_BIT_ALT_GATE    = 1;
  localparam int          LFG_BIT_GATE        = 0;
  localparam int          LFG_BIT_PORT_EN     = 0;
  localparam logic [1:0]  LFG_PORT_BYTE_RST   = 2'h0;
  localparam logic        LFG_GATE_CTL_RST    = 1'h1;
  localparam logic        LFG_PORT_EN_RST     = 1'h0;
  localparam logic [7:0]  LFG_ZERO_BYTE       = 8'h00;
  // logical device number: arbitrary value
  localparam logic [7:0]  LFG_LDN_DEFAULT     = 8'h01;
endpackage : lfg_pkg

/* File: inc/lfg_port_if.sv */
// carrier between the main block and the legacy port byte register
`timescale 1ns/1ps
interface lfg_port_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       alt_gate;

  modport ctl  (output wr, output wdata, input rdata, input alt_gate);
  modport regs (input wr, input wdata, output rdata, output alt_gate);
endinterface : lfg_port_if

/* File: design/lfg_port_regs.sv */
// legacy port byte: alternate gate and alternate cpu reset bits
`timescale 1ns/1ps
module lfg_port_regs
  import lfg_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  host_rst_i,
  lfg_port_if.regs   port
);
  logic alt_gate_r;
  logic alt_reset_r;

  // R4: write sets or clears alternate gate
  always_ff @(posedge clk_i) begin
    if (host_rst_i) begin
      alt_gate_r <= LFG_PORT_BYTE_RST[LFG_BIT_ALT_GATE];
    end else if (port.wr) begin
      alt_gate_r <= port.wdata[LFG_BIT_ALT_GATE];
    end
  end

  // R15: cpu reset bit is stored and read back on port.rdata
  always_ff @(posedge clk_i) begin
    if (host_rst_i) begin
      alt_reset_r <= LFG_PORT_BYTE_RST[LFG_BIT_ALT_RESET];
    end else if (port.wr) begin
      alt_reset_r <= port.wdata[LFG_BIT_ALT_RESET];
    end
  end

  // R5: upper bits read as zero
  always_comb begin
    port.rdata                    = LFG_ZERO_BYTE;
    port.rdata[LFG_BIT_ALT_GATE]  = alt_gate_r;
    port.rdata[LFG_BIT_ALT_RESET] = alt_reset_r;
  end

  assign port.alt_gate = alt_gate_r;
endmodule : lfg_port_regs

/* File: design/lfg_gate_top.sv */
// legacy fast gate logic: host port byte, port enable, controller gate registers
//
// What this block does
// R1: host writes to io 92h are dropped while the port enable bit is 0 and taken while it is 1.
// R2: the gate output is low only when the alternate gate and the keyboard gate request are low.
// R3: a high alternate gate forces the gate output high whatever the keyboard request.
// R4: an enabled host write of bit 1 sets the alternate gate to that value.
// R5: the port byte holds alternate gate in bit 1 and cpu reset in bit 0, host reset to 0, rest 0.
// R6: gate control bit 0 sets the gate level, host reset to 1, upper bits read 0.
// R7: any controller write to the set strobe sets the gate control bit.
// R8: any controller write to the reset strobe clears the gate control bit.
// R9: the host reaches the enable register through the config port, device number then index 30h.
// R10: the controller reaches the enable register at offset 330h directly.
// R11: the port byte is at host io 0092h and at controller offset 0.
// R12: the enable bit is bit 0, read/write, cleared by main-power reset, upper bits read 0.
// R13: with software assist on only firmware moves the gate, else the latest of host or firmware.
// R14: the keyboard gate request is the gate control bit, ORed with the alternate gate.
// R15: the alternate cpu reset bit is stored, read back and driven on alternate_cpu_reset_o.
`timescale 1ns/1ps
module lfg_gate_top
  import lfg_pkg::*;
#(
  parameter logic [7:0] LDN = LFG_LDN_DEFAULT
)(
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                host_rst_i,
  input  wire logic [15:0]         lpc_io_addr_i,
  input  wire logic                lpc_io_wr_i,
  input  wire logic                lpc_io_rd_i,
  input  wire logic [7:0]          lpc_io_wdata_i,
  output logic                     lpc_io_hit_o,
  output logic [7:0]               lpc_io_rdata_o,
  input  wire logic [7:0]          cfg_ldn_i,
  input  wire logic [7:0]          cfg_index_i,
  input  wire logic                cfg_wr_i,
  input  wire logic                cfg_rd_i,
  input  wire logic [7:0]          cfg_wdata_i,
  output logic                     cfg_hit_o,
  output logic [7:0]               cfg_rdata_o,
  input  wire logic [LFG_EC_AW-1:0] ec_addr_i,
  input  wire logic                ec_wr_i,
  input  wire logic                ec_rd_i,
  input  wire logic [7:0]          ec_wdata_i,
  output logic [7:0]               ec_rdata_o,
  input  wire logic                software_assist_enable_i,
  input  wire logic                kbd_gate_wr_i,
  input  wire logic                kbd_gate_val_i,
  output logic                     address_line_gate_o,
  output logic                     alternate_cpu_reset_o
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic host_rst;
  logic legacy_port_enable_bit_r;
  logic keyboard_gate_request_r;
  logic ec_hit_port;
  logic ec_hit_ctl;
  logic ec_hit_set;
  logic ec_hit_rst;
  logic ec_hit_en;
  logic lpc_port_wr;
  logic cfg_en_wr;
  logic [7:0] ec_rd_mux;

  lfg_port_if port_if ();

  // main-power reset also resets everything in the host domain
  assign host_rst = sys_rst_i | host_rst_i;

  function automatic logic ec_at(input logic [LFG_EC_AW-1:0] a,
                                 input logic [LFG_EC_AW-1:0] off);
    ec_at = (a == off);
  endfunction : ec_at

  function automatic logic [7:0] one_bit(input logic b);
    one_bit    = LFG_ZERO_BYTE;
    one_bit[0] = b;
  endfunction : one_bit

  // R11: port byte at io 0092h and controller offset 0
  assign lpc_io_hit_o = (lpc_io_addr_i == LFG_LPC_PORT_ADDR);
  assign ec_hit_port  = ec_at(ec_addr_i, LFG_OFF_PORT_BYTE);
  assign ec_hit_ctl   = ec_at(ec_addr_i, LFG_OFF_GATE_CTL);
  assign ec_hit_set   = ec_at(ec_addr_i, LFG_OFF_GATE_SET);
  assign ec_hit_rst   = ec_at(ec_addr_i, LFG_OFF_GATE_RST);
  // R10: direct controller path to the enable register
  assign ec_hit_en    = ec_at(ec_addr_i, LFG_OFF_PORT_EN);
  // R9: config path needs our device number and index 30h
  assign cfg_hit_o    = (cfg_ldn_i == LDN) && (cfg_index_i == LFG_CFG_ENABLE_IDX);
  assign cfg_en_wr    = cfg_wr_i && cfg_hit_o;

  // R1: host writes only land while the port is enabled
  assign lpc_port_wr  = lpc_io_wr_i && lpc_io_hit_o && legacy_port_enable_bit_r;

  // controller writes to the byte are not gated by the enable bit
  assign port_if.wr    = lpc_port_wr || (ec_wr_i && ec_hit_port);
  assign port_if.wdata = lpc_port_wr ? lpc_io_wdata_i : ec_wdata_i;

  lfg_port_regs u_port_regs (
    .clk_i      (clk_i),
    .host_rst_i (host_rst),
    .port       (port_if.regs)
  );

  // ---------------------------------------------------------------
  // port enable
  // ---------------------------------------------------------------
  // R12: enable bit, main-power reset only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      legacy_port_enable_bit_r <= LFG_PORT_EN_RST;
    end else if (ec_wr_i && ec_hit_en) begin
      legacy_port_enable_bit_r <= ec_wdata_i[LFG_BIT_PORT_EN];
    end else if (cfg_en_wr) begin
      legacy_port_enable_bit_r <= cfg_wdata_i[LFG_BIT_PORT_EN];
    end
  end

  // ---------------------------------------------------------------
  // gate control
  // ---------------------------------------------------------------
  // R6: control bit resets high on host reset
  // R7: set strobe writes 1
  // R8: reset strobe writes 0
  // R13: keyboard path only acts with software assist off; firmware wins a tie
  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      keyboard_gate_request_r <= LFG_GATE_CTL_RST;
    end else if (ec_wr_i && ec_hit_ctl) begin
      keyboard_gate_request_r <= ec_wdata_i[LFG_BIT_GATE];
    end else if (ec_wr_i && ec_hit_set) begin
      keyboard_gate_request_r <= 1'b1;
    end else if (ec_wr_i && ec_hit_rst) begin
      keyboard_gate_request_r <= 1'b0;
    end else if (kbd_gate_wr_i && !software_assist_enable_i) begin
      keyboard_gate_request_r <= kbd_gate_val_i;
    end
  end

  // R2: low only when both sources are low
  // R3: alternate gate high forces high
  // R14: output is the OR of both
  assign address_line_gate_o   = keyboard_gate_request_r | port_if.alt_gate;
  // R15: the stored bit is exposed for the integrator
  assign alternate_cpu_reset_o = port_if.rdata[LFG_BIT_ALT_RESET];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // unmapped offsets and the write-only strobes read as zero
  always_comb begin
    ec_rd_mux = LFG_ZERO_BYTE;
    if (ec_hit_port) begin
      ec_rd_mux = port_if.rdata;
    end else if (ec_hit_ctl) begin
      ec_rd_mux = one_bit(keyboard_gate_request_r);
    end else if (ec_hit_en) begin
      ec_rd_mux = one_bit(legacy_port_enable_bit_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ec_rdata_o <= LFG_ZERO_BYTE;
    end else if (ec_rd_i) begin
      ec_rdata_o <= ec_rd_mux;
    end
  end

  // host reads the byte even while writes are disabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lpc_io_rdata_o <= LFG_ZERO_BYTE;
    end else if (lpc_io_rd_i && lpc_io_hit_o) begin
      lpc_io_rdata_o <= port_if.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= LFG_ZERO_BYTE;
    end else if (cfg_rd_i && cfg_hit_o) begin
      cfg_rdata_o <= one_bit(legacy_port_enable_bit_r);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (host_rst);

  sequence host_byte_write_s(logic v);
    lpc_io_wr_i && lpc_io_hit_o && !ec_wr_i && (lpc_io_wdata_i[LFG_BIT_ALT_GATE] == v);
  endsequence

  sequence ec_only_s(logic [LFG_EC_AW-1:0] off);
    ec_wr_i && ec_at(ec_addr_i, off) && !lpc_port_wr;
  endsequence

  disabled_write_drop_a: assert property ( // R1
    (lpc_io_wr_i && lpc_io_hit_o && !legacy_port_enable_bit_r && !ec_wr_i)
      |=> $stable(port_if.rdata))
    else $error("host write landed while port disabled");

  gate_low_cause_a: assert property ( // R2
    !address_line_gate_o |-> (!port_if.alt_gate && !keyboard_gate_request_r))
    else $error("gate low while a source is high");

  alt_forces_high_a: assert property ( // R3
    port_if.alt_gate |-> address_line_gate_o)
    else $error("alternate gate high but output low");

  // a back-to-back host write may lower the bit again, so only the next cycle is checked
  enabled_write_take_a: assert property ( // R4
    (legacy_port_enable_bit_r ##0 host_byte_write_s(1'b1))
      |=> (port_if.alt_gate && address_line_gate_o))
    else $error("enabled host write of 1 did not raise gate");

  upper_bits_zero_a: assert property ( // R5
    port_if.rdata[7:2] == 6'h00)
    else $error("port byte upper bits not zero");

  set_strobe_high_a: assert property ( // R7
    ec_only_s(LFG_OFF_GATE_SET) |=> keyboard_gate_request_r)
    else $error("set strobe did not set gate bit");

  reset_strobe_low_a: assert property ( // R8
    ec_only_s(LFG_OFF_GATE_RST) ##1 !port_if.alt_gate |-> !address_line_gate_o)
    else $error("reset strobe did not clear gate");

  enable_path_a: assert property ( // R10
    ec_only_s(LFG_OFF_PORT_EN)
      |=> (legacy_port_enable_bit_r == $past(ec_wdata_i[LFG_BIT_PORT_EN])))
    else $error("controller enable write lost");

  assist_blocks_kbd_a: assert property ( // R13
    (kbd_gate_wr_i && software_assist_enable_i && !ec_wr_i)
      |=> $stable(keyboard_gate_request_r))
    else $error("keyboard path moved gate under software assist");
endmodule : lfg_gate_top

/* File: tb/lfg_host_model.sv */
// host processor model: lpc io cycles and config port accesses
`timescale 1ns/1ps
module lfg_host_model (
  input  wire logic        clk_i,
  output logic [15:0]      lpc_io_addr_o,
  output logic             lpc_io_wr_o,
  output logic             lpc_io_rd_o,
  output logic [7:0]       lpc_io_wdata_o,
  input  wire logic [7:0]  lpc_io_rdata_i,
  output logic [7:0]       cfg_ldn_o,
  output logic [7:0]       cfg_index_o,
  output logic             cfg_wr_o,
  output logic             cfg_rd_o,
  output logic [7:0]       cfg_wdata_o,
  input  wire logic [7:0]  cfg_rdata_i
);
  initial begin
    {lpc_io_addr_o, lpc_io_wdata_o, lpc_io_wr_o, lpc_io_rd_o} = '0;
    {cfg_ldn_o, cfg_index_o, cfg_wdata_o, cfg_wr_o, cfg_rd_o} = '0;
  end
  // ---------------------------------------------------------------
  // byte cycle; released lines show the inverse, not the old value
  // ---------------------------------------------------------------
  task automatic io_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    lpc_io_addr_o  <= a;
    lpc_io_wdata_o <= d;
    lpc_io_wr_o    <= wr;
    lpc_io_rd_o    <= ~wr;
    @(posedge clk_i);
    lpc_io_addr_o  <= ~a;
    lpc_io_wdata_o <= ~d;
    lpc_io_wr_o    <= 1'b0;
    lpc_io_rd_o    <= 1'b0;
    #1 q = lpc_io_rdata_i;
  endtask : io_cyc
  // ---------------------------------------------------------------
  // device number and index driven in the same cycle through the config port
  // ---------------------------------------------------------------
  task automatic cfg_cyc(input logic wr, input logic [7:0] l, input logic [7:0] i,
                         input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cfg_ldn_o   <= l;
    cfg_index_o <= i;
    cfg_wdata_o <= d;
    cfg_wr_o    <= wr;
    cfg_rd_o    <= ~wr;
    @(posedge clk_i);
    cfg_ldn_o   <= ~l;
    cfg_index_o <= ~i;
    cfg_wdata_o <= ~d;
    cfg_wr_o    <= 1'b0;
    cfg_rd_o    <= 1'b0;
    #1 q = cfg_rdata_i;
  endtask : cfg_cyc
endmodule : lfg_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the legacy fast gate block
`timescale 1ns/1ps
module tb_top
  import lfg_pkg::*;
;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, host_rst_i = 1'b0;
  logic [15:0] io_a;
  logic io_wr, io_rd, io_hit, cfg_wr, cfg_rd, cfg_hit, gate, cpu_rst;
  logic [7:0] io_d, io_q, ldn, idx, cfg_d, cfg_q, ec_q, q;
  logic [11:0] ec_a = '0;
  logic ec_wr = 1'b0, ec_rd = 1'b0, software_assist_enable = 1'b0, kbd_wr = 1'b0, kbd_val = 1'b0;
  logic [7:0] ec_d = '0;
  int n_fail = 0, compares = 0, cycles = 0;
  logic io_seen = 1'b0, cfg_seen = 1'b0;

  // decode hits as seen at the edge that takes each host cycle
  always @(posedge clk_i) begin
    if (io_wr || io_rd) begin
      io_seen <= io_hit;
    end
    if (cfg_wr || cfg_rd) begin
      cfg_seen <= cfg_hit;
    end
  end

  always #25 clk_i = ~clk_i;

  lfg_gate_top i_lfg_gate_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_rst_i(host_rst_i),
    .lpc_io_addr_i(io_a), .lpc_io_wr_i(io_wr), .lpc_io_rd_i(io_rd), .lpc_io_wdata_i(io_d),
    .lpc_io_hit_o(io_hit), .lpc_io_rdata_o(io_q), .cfg_ldn_i(ldn), .cfg_index_i(idx),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_wdata_i(cfg_d), .cfg_hit_o(cfg_hit),
    .cfg_rdata_o(cfg_q), .ec_addr_i(ec_a), .ec_wr_i(ec_wr), .ec_rd_i(ec_rd),
    .ec_wdata_i(ec_d), .ec_rdata_o(ec_q), .software_assist_enable_i(software_assist_enable),
    .kbd_gate_wr_i(kbd_wr), .kbd_gate_val_i(kbd_val), .address_line_gate_o(gate),
    .alternate_cpu_reset_o(cpu_rst));

  lfg_host_model i_host (.clk_i(clk_i), .lpc_io_addr_o(io_a), .lpc_io_wr_o(io_wr),
    .lpc_io_rd_o(io_rd), .lpc_io_wdata_o(io_d), .lpc_io_rdata_i(io_q), .cfg_ldn_o(ldn),
    .cfg_index_o(idx), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_wdata_o(cfg_d),
    .cfg_rdata_i(cfg_q));

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic ec_cyc(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ec_a  <= a;
    ec_d  <= d;
    ec_wr <= wr;
    ec_rd <= ~wr;
    @(posedge clk_i);
    ec_wr <= 1'b0;
    ec_rd <= 1'b0;
    ec_d  <= ~d;
    #1 q = ec_q;
  endtask : ec_cyc

  task automatic kbd(input logic v);
    @(posedge clk_i);
    kbd_wr  <= 1'b1;
    kbd_val <= v;
    @(posedge clk_i);
    kbd_wr  <= 1'b0;
    #1;
  endtask : kbd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic ecr(input logic [11:0] a, input logic [7:0] exp);
    ec_cyc(1'b0, a, 8'h00);
    chk(q, exp, "ec read");
  endtask : ecr

  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ecr(LFG_OFF_PORT_BYTE, 8'h00);
    ecr(LFG_OFF_GATE_CTL, 8'h01);
    ecr(LFG_OFF_PORT_EN, 8'h00);
    ecr(LFG_OFF_GATE_SET, 8'h00);
    ecr(12'h204, 8'h00);
    chk({7'h00, gate}, 8'h01, "gate after reset");
    $display("test reset done");
    i_host.io_cyc(1'b1, LFG_LPC_PORT_ADDR, 8'h02, q);
    i_host.io_cyc(1'b0, LFG_LPC_PORT_ADDR, 8'h00, q);
    chk(q, 8'h00, "disabled write");
    chk({7'h00, io_seen}, 8'h01, "io hit while disabled");
    i_host.cfg_cyc(1'b1, LFG_LDN_DEFAULT, LFG_CFG_ENABLE_IDX, 8'h01, q);
    i_host.cfg_cyc(1'b1, LFG_LDN_DEFAULT, 8'h31, 8'h00, q);
    chk({7'h00, cfg_seen}, 8'h00, "cfg other index");
    i_host.cfg_cyc(1'b0, LFG_LDN_DEFAULT, LFG_CFG_ENABLE_IDX, 8'h00, q);
    chk(q, 8'h01, "cfg enable");
    chk({7'h00, cfg_seen}, 8'h01, "cfg hit");
    ecr(LFG_OFF_PORT_EN, 8'h01);
    $display("test enable done");
    i_host.io_cyc(1'b1, LFG_LPC_PORT_ADDR ^ 16'h0001, 8'h03, q);
    chk({7'h00, io_seen}, 8'h00, "io miss next address");
    ec_cyc(1'b1, LFG_OFF_GATE_RST, 8'h5a);
    ecr(LFG_OFF_GATE_CTL, 8'h00);
    chk({7'h00, gate}, 8'h00, "gate low");
    i_host.io_cyc(1'b1, LFG_LPC_PORT_ADDR, 8'hff, q);
    i_host.io_cyc(1'b0, LFG_LPC_PORT_ADDR, 8'h00, q);
    chk(q, 8'h03, "port byte");
    chk({6'h00, cpu_rst, gate}, 8'h03, "alt high");
    i_host.io_cyc(1'b1, LFG_LPC_PORT_ADDR, 8'h01, q);
    chk({6'h00, cpu_rst, gate}, 8'h02, "alt low");
    ecr(LFG_OFF_PORT_BYTE, 8'h01);
    ec_cyc(1'b1, LFG_OFF_GATE_SET, 8'h00);
    ecr(LFG_OFF_GATE_CTL, 8'h01);
    chk({7'h00, gate}, 8'h01, "gate or");
    $display("test gate done");
    ec_cyc(1'b1, LFG_OFF_PORT_EN, 8'hfe);
    ecr(LFG_OFF_PORT_EN, 8'h00);
    i_host.io_cyc(1'b1, LFG_LPC_PORT_ADDR, 8'h02, q);
    ecr(LFG_OFF_PORT_BYTE, 8'h01);
    kbd(1'b0);
    chk({7'h00, gate}, 8'h00, "kbd moves gate");
    software_assist_enable <= 1'b1;
    kbd(1'b1);
    chk({7'h00, gate}, 8'h00, "kbd blocked");
    chk({7'h00, cpu_rst}, 8'h01, "cpu reset bit");
    $display("test assist done");
    ec_cyc(1'b1, LFG_OFF_PORT_EN, 8'h01);
    @(posedge clk_i);
    host_rst_i <= 1'b1;
    @(posedge clk_i);
    host_rst_i <= 1'b0;
    ecr(LFG_OFF_PORT_BYTE, 8'h00);
    ecr(LFG_OFF_GATE_CTL, 8'h01);
    ecr(LFG_OFF_PORT_EN, 8'h01);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ecr(LFG_OFF_PORT_EN, 8'h00);
    $display("test resets done");
    stop_test();
  end
endmodule : tb_top
